/* common/hpr_pkg.sv */
// package for the raw channel: register map, fields, resets and framing constants
package hpr_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_IFIELD = 8'h04;
  localparam logic [7:0] OFF_SHORT  = 8'h08;
  localparam logic [7:0] OFF_PKTLEN = 8'h0c;
  localparam logic [7:0] OFF_CMD    = 8'h10;
  localparam logic [7:0] OFF_TXLO   = 8'h14;
  localparam logic [7:0] OFF_TXHI   = 8'h18;
  localparam logic [7:0] OFF_WRLEN  = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_RXLO   = 8'h24;
  localparam logic [7:0] OFF_RXHI   = 8'h28;
  localparam logic [7:0] OFF_RXCNT  = 8'h2c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_LONG_TERM  = 0;
  localparam int CTRL_MULTI      = 1;
  localparam int CTRL_SHORT_EN   = 2;
  localparam int CTRL_RX_EN      = 3;
  localparam int CTRL_W          = 4;
  localparam int CMD_END_PKT     = 0;
  localparam int CMD_DISCONNECT  = 1;
  localparam int ST_CONNECTED    = 0;
  localparam int ST_PACKET       = 1;
  localparam int ST_TX_FULL      = 2;
  localparam int ST_RX_AVAIL     = 3;
  localparam int ST_LOSS         = 4;
  localparam int ST_RX_FIRST     = 5;
  localparam int ST_RX_FULL      = 6;
  // ----------------------------------------------------------------
  // reset values and framing figures
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTRL_RST        = 4'h0;
  localparam logic [31:0] IFIELD_RST      = 32'h0000_0000;
  localparam logic [7:0]  SHORT_RST       = 8'h01;
  localparam logic [8:0]  STD_BURST_WORDS = 9'h100;
  localparam int          WORD_BYTES      = 8;
  localparam int          MAX_WRITE_BYTES = 16 * 1024 * 1024;
  localparam int          MAX_WRITE_WORDS = MAX_WRITE_BYTES / WORD_BYTES;
  localparam int          WRLEN_W         = 22;
  localparam logic [31:0] RXCNT_STEP      = 32'h0000_0008;
endpackage

/* dv/hpr_channel_tb.sv */
// self-checking testbench for the raw channel
`timescale 1ns/10ps
module hpr_channel_tb;
  localparam int DEPTH = 4;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lo;
  logic        pready, pslverr, er, tx_req, tx_con, tx_pkt, tx_val, tx_last;
  logic        rx_req, rx_con, rx_pkt, rx_val;
  logic [31:0] tx_if;
  logic [63:0] tx_dat, rx_dat;
  int          num_errors = 0;
  int          checked = 0;
  always #10 clk = ~clk;
  hpr_channel #(.RX_DEPTH(DEPTH)) dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_tx_request(tx_req),
    .o_tx_ifield(tx_if), .i_tx_connect(tx_con), .o_tx_packet(tx_pkt), .o_tx_valid(tx_val),
    .o_tx_burst_last(tx_last), .o_tx_data(tx_dat), .i_rx_request(rx_req),
    .o_rx_connect(rx_con), .i_rx_packet(rx_pkt), .i_rx_valid(rx_val), .i_rx_data(rx_dat));
  hpr_link_peer peer_u (.i_clk(clk), .i_nrst(nrst), .i_tx_request(tx_req),
    .i_tx_ifield(tx_if), .o_tx_connect(tx_con), .i_tx_packet(tx_pkt), .i_tx_valid(tx_val),
    .i_tx_burst_last(tx_last), .i_tx_data(tx_dat), .o_rx_request(rx_req),
    .i_rx_connect(rx_con), .o_rx_packet(rx_pkt), .o_rx_valid(rx_val), .o_rx_data(rx_dat));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1, "apb no answer");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // host words are whole 8-byte units, held until the slot frees
  // word-aligned host units
  task automatic push(input logic [63:0] w);
    int n = 0;
    do begin
      apb(1'b0, hpr_pkg::OFF_STATUS, 32'h0);
      n++;
    end while (rd[hpr_pkg::ST_TX_FULL] !== 1'b0 && n < 50);
    wr(hpr_pkg::OFF_TXLO, w[31:0]);
    wr(hpr_pkg::OFF_TXHI, w[63:32]);
  endtask
  // one host write per word; length is set only once the slot holds the word
  task automatic mw(input int k, input logic [63:0] base);
    for (int i = 0; i < k; i++) begin
      push(base + 64'(i));
      wr(hpr_pkg::OFF_WRLEN, 32'h8);
    end
  endtask
  task automatic wait_pkt(input int k);
    int n = 0;
    while (peer_u.pkt_ends != k && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(n < 500, 1'b1, "packet end");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, hpr_pkg::OFF_SHORT, 32'h0);
    chk(rd, 32'h1, "short reset");
    apb(1'b0, hpr_pkg::OFF_RXCNT, 32'h0);
    chk(rd, 32'h0, "count reset");
    apb(1'b0, 8'h3c, 32'h0);
    chk(er, 1'b1, "unmapped err");
    wr(hpr_pkg::OFF_WRLEN, 32'hffff_fff8);
    apb(1'b0, hpr_pkg::OFF_WRLEN, 32'h0);
    chk(rd, 32'(hpr_pkg::MAX_WRITE_WORDS), "write clip");
    wr(hpr_pkg::OFF_WRLEN, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_tx;
    wr(hpr_pkg::OFF_IFIELD, 32'hc3a5_0f96);
    wr(hpr_pkg::OFF_CTRL, 32'h0);
    wr(hpr_pkg::OFF_WRLEN, 32'h10);
    push(64'h0123_4567_89ab_cdef);
    push(64'hfedc_ba98_7654_3210);
    wait_pkt(1);
    chk(peer_u.ifield, 32'hc3a5_0f96, "ifield");
    chk(peer_u.words.size(), 2, "word count");
    chk(peer_u.words[1], 64'hfedc_ba98_7654_3210, "tx data");
    chk(peer_u.lasts[0], 1'b0, "std burst");
    chk(tx_req, 1'b0, "auto close");
    wr(hpr_pkg::OFF_IFIELD, 32'h0000_0001);
    wr(hpr_pkg::OFF_CTRL, 32'h1);
    wr(hpr_pkg::OFF_WRLEN, 32'h8);
    push(64'h0000_0000_0000_0005);
    wait_pkt(2);
    chk(tx_req, 1'b1, "long held");
    chk(peer_u.ifield, 32'h0000_0001, "new ifield");
    wr(hpr_pkg::OFF_CMD, 32'h2);
    repeat (10) @(posedge clk);
    chk(tx_req, 1'b0, "disconnect");
    $display("test tx done");
  endtask
  task automatic t_multi;
    wr(hpr_pkg::OFF_CTRL, 32'h2);
    wr(hpr_pkg::OFF_PKTLEN, 32'h4);
    mw(2, 64'h0a0a_0000_0000_0000);
    repeat (20) @(posedge clk);
    chk(tx_pkt, 1'b1, "packet spans writes");
    wr(hpr_pkg::OFF_CMD, 32'h1);
    wait_pkt(3);
    chk(peer_u.words.size(), 5, "early end words");
    wr(hpr_pkg::OFF_PKTLEN, 32'h0);
    mw(2, 64'h0b0b_0000_0000_0000);
    repeat (20) @(posedge clk);
    chk(tx_pkt, 1'b1, "unbounded packet");
    chk(peer_u.words.size(), 7, "unbounded words");
    wr(hpr_pkg::OFF_CMD, 32'h1);
    wait_pkt(4);
    wr(hpr_pkg::OFF_PKTLEN, 32'h2);
    mw(2, 64'h0c0c_0000_0000_0000);
    wait_pkt(5);
    chk(peer_u.words.size(), 9, "count end words");
    chk(peer_u.words[8], 64'h0c0c_0000_0000_0001, "count end data");
    wr(hpr_pkg::OFF_CTRL, 32'h4);
    wr(hpr_pkg::OFF_SHORT, 32'h1);
    wr(hpr_pkg::OFF_WRLEN, 32'h10);
    push(64'h5555_6666_7777_8888);
    push(64'h9999_aaaa_bbbb_cccc);
    wait_pkt(6);
    chk(peer_u.words[9], 64'h5555_6666_7777_8888, "short data");
    chk(peer_u.lasts[9], 1'b1, "short burst");
    $display("test multi done");
  endtask
  task automatic t_rx(input int n, input logic [63:0] base);
    wr(hpr_pkg::OFF_CTRL, 32'h8);
    peer_u.send_pkt(n, base);
    chk(peer_u.conn_k < 3, 1'b1, "auto accept");
    apb(1'b0, hpr_pkg::OFF_STATUS, 32'h0);
    chk(rd[hpr_pkg::ST_RX_FIRST], 1'b1, "start mark");
    chk(rd[hpr_pkg::ST_LOSS], n > DEPTH, "loss flag");
    wr(hpr_pkg::OFF_STATUS, 32'h10);
    apb(1'b0, hpr_pkg::OFF_STATUS, 32'h0);
    chk(rd[hpr_pkg::ST_LOSS], 1'b0, "loss clear");
    for (int i = 0; i < n && i < DEPTH; i++) begin
      apb(1'b0, hpr_pkg::OFF_RXLO, 32'h0);
      lo = rd;
      apb(1'b0, hpr_pkg::OFF_RXHI, 32'h0);
      chk({rd, lo}, base + 64'(i), "rx order");
      apb(1'b0, hpr_pkg::OFF_RXCNT, 32'h0);
      chk(rd, 32'(8 * (i + 1)), "rx count");
    end
    apb(1'b0, hpr_pkg::OFF_RXHI, 32'h0);
    chk(er, 1'b1, "empty pop");
    $display("test rx done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_multi();
    t_rx(2, 64'h1111_2222_3333_4440);
    t_rx(DEPTH + 2, 64'h4444_0000_0000_0100);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule

/* dv/hpr_link_peer.sv */
// link peer model: accepts outbound connections, records words, sends inbound packets
`timescale 1ns/10ps
module hpr_link_peer #(
  parameter int CONN_DLY = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_tx_request,
  input  wire logic [31:0] i_tx_ifield,
  output logic             o_tx_connect,
  input  wire logic        i_tx_packet,
  input  wire logic        i_tx_valid,
  input  wire logic        i_tx_burst_last,
  input  wire logic [63:0] i_tx_data,
  output logic             o_rx_request,
  input  wire logic        i_rx_connect,
  output logic             o_rx_packet,
  output logic             o_rx_valid,
  output logic [63:0]      o_rx_data
);
  logic [63:0] words[$];
  logic        lasts[$];
  logic [31:0] ifield;
  int          pkt_ends;
  int          wait_n;
  int          conn_k;
  logic        pkt_q;
  initial begin
    o_rx_request = 1'b0;
    o_rx_packet  = 1'b0;
    o_rx_valid   = 1'b0;
    o_rx_data    = 64'h0;
  end
  // ----------------------------------------------------------------
  // outbound side
  // ----------------------------------------------------------------
  // accepts after a delay, so a slow switch is seen
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_n       <= 0;
      o_tx_connect <= 1'b0;
      pkt_q        <= 1'b0;
      pkt_ends     <= 0;
    end else begin
      pkt_q        <= i_tx_packet;
      wait_n       <= i_tx_request ? wait_n + 1 : 0;
      o_tx_connect <= i_tx_request && (wait_n >= CONN_DLY);
      if (!i_tx_packet && pkt_q) begin
        pkt_ends <= pkt_ends + 1;
      end
      if (i_tx_request && wait_n == 0) begin
        ifield <= i_tx_ifield;
      end
      if (i_tx_valid) begin
        words.push_back(i_tx_data);
        lasts.push_back(i_tx_burst_last);
      end
    end
  end
  // ----------------------------------------------------------------
  // inbound side
  // ----------------------------------------------------------------
  // waits for acceptance; data inverts once released so stale words never match
  task automatic send_pkt(input int n, input logic [63:0] base);
    conn_k = 0;
    @(posedge i_clk);
    o_rx_request <= 1'b1;
    while (i_rx_connect !== 1'b1 && conn_k < 50) begin
      @(posedge i_clk);
      conn_k++;
    end
    o_rx_packet <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_rx_valid <= 1'b1;
      o_rx_data  <= base + 64'(i);
      @(posedge i_clk);
    end
    o_rx_valid   <= 1'b0;
    o_rx_packet  <= 1'b0;
    o_rx_request <= 1'b0;
    o_rx_data    <= ~(base + 64'(n - 1));
    @(posedge i_clk);
  endtask
endmodule

/* verilog/hpr_channel.sv */
// raw physical-layer channel: apb registers, transmit framer, receive queue
//
// Functional notes
// - accept every arriving packet, no sorting by protocol identifier
// - store each packet whole, headers untouched and unparsed; a packet that fills the receive memory keeps only the words already stored
// - keep a host-readable byte count of the current received packet
// - per-packet or long-term connections; long-term closes on host request
// - multi-write keeps packet up; single-write drops it after the write
// - one host write carries at most 16 megabytes
// - packets may be unbounded until the host ends them
// - short-burst setting makes each packet's first burst short
// - host may end a multi-write packet before its declared count
// - no framing header needed; any I-field value allowed
// - send only host data; config is I-field and short-burst setting
// - present configured I-field unchanged on every connection request
// - incoming I-field is neither read nor altered
// - short first burst length set by host, data from first write
// - received packets leave in strict arrival order
// - full receive memory drops new packets and flags a loss
// - one connection at a time; request only after teardown
// - receiver accepts connections automatically once enabled
// - short burst 1 to 255 words, standard burst 256 words
// - per-packet mode closes the connection after the packet
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module hpr_channel #(
  parameter int RX_DEPTH = 16
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic             o_tx_request,
  output logic [31:0]      o_tx_ifield,
  input  wire logic        i_tx_connect,
  output logic             o_tx_packet,
  output logic             o_tx_valid,
  output logic             o_tx_burst_last,
  output logic [63:0]      o_tx_data,
  input  wire logic        i_rx_request,
  output logic             o_rx_connect,
  input  wire logic        i_rx_packet,
  input  wire logic        i_rx_valid,
  input  wire logic [63:0] i_rx_data
);
  localparam int AW = $clog2(RX_DEPTH);
  typedef enum logic [1:0] {TX_IDLE, TX_CONN, TX_OPEN, TX_PKT} hpr_tx_state_t;
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [8:0] burst_limit(input logic first, input logic en,
                                             input logic [7:0] words);
    burst_limit = (first && en) ? {1'b0, words | {7'h0, ~|words}} : hpr_pkg::STD_BURST_WORDS;
  endfunction
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(RX_DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction
  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [3:0]          ctrl;
  logic [31:0]         ifield;
  logic [7:0]          short_words;
  logic [31:0]         pkt_len;
  logic [31:0]         tx_lo;
  logic [63:0]         tx_hold;
  logic                tx_full;
  logic [hpr_pkg::WRLEN_W-1:0] wr_left;
  logic [31:0]         pkt_left;
  logic [8:0]          burst_cnt;
  logic                first_burst;
  hpr_tx_state_t       tx_state;
  logic [64:0]         rx_mem [RX_DEPTH];
  logic [AW-1:0]       wr_ptr;
  logic [AW-1:0]       rd_ptr;
  logic [AW:0]         rx_used;
  logic                rx_first_pend;
  logic                rx_dropping;
  logic                loss;
  logic [31:0]         rx_count;
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc      = i_psel & i_penable & ~o_pready;
  wire done     = i_psel & i_penable & o_pready;
  wire wr_done  = done & i_pwrite & ~o_pslverr;
  wire rd_done  = done & ~i_pwrite & ~o_pslverr;
  wire a_ctrl   = i_paddr == hpr_pkg::OFF_CTRL;
  wire a_ifield = i_paddr == hpr_pkg::OFF_IFIELD;
  wire a_short  = i_paddr == hpr_pkg::OFF_SHORT;
  wire a_pktlen = i_paddr == hpr_pkg::OFF_PKTLEN;
  wire a_cmd    = i_paddr == hpr_pkg::OFF_CMD;
  wire a_txlo   = i_paddr == hpr_pkg::OFF_TXLO;
  wire a_txhi   = i_paddr == hpr_pkg::OFF_TXHI;
  wire a_wrlen  = i_paddr == hpr_pkg::OFF_WRLEN;
  wire a_status = i_paddr == hpr_pkg::OFF_STATUS;
  wire a_rxlo   = i_paddr == hpr_pkg::OFF_RXLO;
  wire a_rxhi   = i_paddr == hpr_pkg::OFF_RXHI;
  wire a_rxcnt  = i_paddr == hpr_pkg::OFF_RXCNT;
  wire rx_empty = rx_used == '0;
  wire rx_full  = rx_used == (AW+1)'(RX_DEPTH);
  wire mapped   = a_ctrl | a_ifield | a_short | a_pktlen | a_cmd | a_txlo | a_txhi
                | a_wrlen | a_status | a_rxlo | a_rxhi | a_rxcnt;
  // refused: unmapped, data push into full holding word, pop of empty queue
  wire refuse   = ~mapped | (i_pwrite & a_txhi & tx_full) | (~i_pwrite & a_rxhi & rx_empty);
  wire [64:0] rx_head = rx_mem[rd_ptr];
  wire [31:0] status_word = {25'h0, rx_full, rx_head[64] & ~rx_empty, loss, ~rx_empty,
                             tx_full, o_tx_packet, (tx_state == TX_OPEN) | (tx_state == TX_PKT)};
  wire [31:0] rd_mux = a_ctrl   ? {28'h0, ctrl} :
                       a_ifield ? ifield :
                       a_short  ? {24'h0, short_words} :
                       a_pktlen ? pkt_len :
                       a_wrlen  ? {{(32-hpr_pkg::WRLEN_W){1'b0}}, wr_left} :
                       a_status ? status_word :
                       a_rxlo   ? rx_head[31:0] :
                       a_rxhi   ? rx_head[63:32] :
                       a_rxcnt  ? rx_count : 32'h0;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc & refuse;
      o_prdata  <= (acc & ~i_pwrite) ? rd_mux : 32'h0;
    end
  end
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // host ends packet
  wire cmd_end  = wr_done & a_cmd & i_pwdata[hpr_pkg::CMD_END_PKT];
  wire cmd_disc = wr_done & a_cmd & i_pwdata[hpr_pkg::CMD_DISCONNECT];
  wire push_tx  = wr_done & a_txhi;
  wire long_term = ctrl[hpr_pkg::CTRL_LONG_TERM];
  wire multi     = ctrl[hpr_pkg::CTRL_MULTI];
  wire [hpr_pkg::WRLEN_W-1:0] wr_req =
    (i_pwdata[31:3] > 29'(hpr_pkg::MAX_WRITE_WORDS)) ?
    hpr_pkg::WRLEN_W'(hpr_pkg::MAX_WRITE_WORDS) : i_pwdata[hpr_pkg::WRLEN_W+2:3];
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl        <= hpr_pkg::CTRL_RST;
      ifield      <= hpr_pkg::IFIELD_RST;
      short_words <= hpr_pkg::SHORT_RST;
      pkt_len     <= 32'h0;
      tx_lo       <= 32'h0;
    end else if (wr_done) begin
      if (a_ctrl) ctrl <= i_pwdata[hpr_pkg::CTRL_W-1:0];
      if (a_ifield) ifield <= i_pwdata;
      if (a_short) short_words <= i_pwdata[7:0];
      if (a_pktlen) pkt_len <= i_pwdata;
      if (a_txlo) tx_lo <= i_pwdata;
    end
  end
  // ----------------------------------------------------------------
  // transmit framer
  // ----------------------------------------------------------------
  // burst word limit
  wire [8:0] blim  = burst_limit(first_burst, ctrl[hpr_pkg::CTRL_SHORT_EN], short_words);
  wire send        = (tx_state == TX_PKT) & tx_full & (wr_left != '0);
  wire blast       = send & (burst_cnt + 9'h001 == blim);
  wire end_single  = ~multi & send & (wr_left == hpr_pkg::WRLEN_W'(1));
  wire end_count   = multi & send & (pkt_len != 32'h0) & (pkt_left == 32'h1);
  wire pkt_end     = (tx_state == TX_PKT) & (cmd_end | end_single | end_count);
  wire pkt_start   = (tx_state == TX_OPEN) & tx_full & (wr_left != '0);
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_state     <= TX_IDLE;
      o_tx_request <= 1'b0;
      o_tx_ifield  <= 32'h0;
      o_tx_packet  <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_full && wr_left != '0) begin
            tx_state     <= TX_CONN;
            o_tx_request <= 1'b1;
            o_tx_ifield  <= ifield;
          end
        end
        TX_CONN: begin
          if (i_tx_connect) tx_state <= TX_OPEN;
        end
        TX_OPEN: begin
          if (cmd_disc) begin
            tx_state     <= TX_IDLE;
            o_tx_request <= 1'b0;
          end else if (pkt_start) begin
            tx_state    <= TX_PKT;
            o_tx_packet <= 1'b1;
          end
        end
        TX_PKT: begin
          if (pkt_end) begin
            o_tx_packet <= 1'b0;
            tx_state     <= long_term ? TX_OPEN : TX_IDLE;
            o_tx_request <= long_term;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_hold         <= 64'h0;
      tx_full         <= 1'b0;
      wr_left         <= '0;
      pkt_left        <= 32'h0;
      burst_cnt       <= 9'h0;
      first_burst     <= 1'b1;
      o_tx_valid      <= 1'b0;
      o_tx_burst_last <= 1'b0;
      o_tx_data       <= 64'h0;
    end else begin
      o_tx_valid      <= send;
      o_tx_burst_last <= blast;
      if (send) o_tx_data <= tx_hold;
      if (push_tx) begin
        tx_hold <= {i_pwdata, tx_lo};
        tx_full <= 1'b1;
      end else if (send) begin
        tx_full <= 1'b0;
      end
      if (wr_done && a_wrlen) wr_left <= wr_req;
      else if (send) wr_left <= wr_left - hpr_pkg::WRLEN_W'(1);
      if (pkt_start) pkt_left <= pkt_len;
      else if (send) pkt_left <= pkt_left - 32'h1;
      if (pkt_start) begin
        burst_cnt   <= 9'h0;
        first_burst <= 1'b1;
      end else if (blast) begin
        burst_cnt   <= 9'h0;
        first_burst <= 1'b0;
      end else if (send) begin
        burst_cnt <= burst_cnt + 9'h001;
      end
    end
  end
  // ----------------------------------------------------------------
  // receive queue
  // ----------------------------------------------------------------
  // incoming i-field is not examined
  wire rx_word  = i_rx_valid & i_rx_packet;
  wire push_rx  = rx_word & ~rx_full & ~rx_dropping;
  wire drop_rx  = rx_word & rx_full;
  wire pop_rx   = rd_done & a_rxhi;
  wire loss_clr = wr_done & a_status & i_pwdata[hpr_pkg::ST_LOSS];
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_connect <= 1'b0;
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      rx_used      <= '0;
      rx_first_pend <= 1'b1;
      rx_dropping  <= 1'b0;
      loss         <= 1'b0;
      rx_count     <= 32'h0;
    end else begin
      o_rx_connect <= i_rx_request & ctrl[hpr_pkg::CTRL_RX_EN];
      if (push_rx) wr_ptr <= ptr_inc(wr_ptr);
      if (pop_rx) rd_ptr <= ptr_inc(rd_ptr);
      rx_used <= rx_used + (AW+1)'(push_rx) - (AW+1)'(pop_rx);
      if (rx_word) rx_first_pend <= 1'b0;
      else if (!i_rx_packet) rx_first_pend <= 1'b1;
      // drop rest of packet, flag loss; set beats clear
      if (drop_rx) rx_dropping <= 1'b1;
      else if (!i_rx_packet) rx_dropping <= 1'b0;
      if (drop_rx) loss <= 1'b1;
      else if (loss_clr) loss <= 1'b0;
      // count restarts at a new packet
      if (pop_rx) rx_count <= rx_head[64] ? hpr_pkg::RXCNT_STEP : rx_count + hpr_pkg::RXCNT_STEP;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (push_rx) rx_mem[wr_ptr] <= {rx_first_pend, i_rx_data};
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_open_req;
    $rose(o_tx_request);
  endsequence
  a_rx_auto_accept: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_rx_request && ctrl[hpr_pkg::CTRL_RX_EN] |=> o_rx_connect)
    else $error("receive request not accepted");
  a_count_restart: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    pop_rx && rx_head[64] |=> rx_count == 32'h8)
    else $error("byte count did not restart");
  a_count_step: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    pop_rx && !rx_head[64] |=> rx_count == $past(rx_count) + 32'h8)
    else $error("byte count did not advance by eight");
  a_burst_bound: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    send |-> burst_cnt < blim && blim <= 9'h100 && blim != 9'h0)
    else $error("burst exceeds its limit");
  a_single_end: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    end_single |=> !o_tx_packet)
    else $error("single-write packet not ended");
  a_early_end: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    cmd_end && tx_state == TX_PKT |=> !o_tx_packet ##1 !o_tx_valid)
    else $error("packet not ended on host request");
  a_ifield_stable: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_tx_request && $past(o_tx_request) |-> $stable(o_tx_ifield))
    else $error("i-field changed during connection");
  a_one_conn: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_open_req |-> $past(tx_state) == TX_IDLE)
    else $error("connection requested while one is up");
  a_per_pkt_close: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    pkt_end && !long_term |=> !o_tx_request && tx_state == TX_IDLE)
    else $error("per-packet connection left open");
  a_loss_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    drop_rx |=> loss && rx_used == $past(rx_used) - (AW+1)'($past(pop_rx)))
    else $error("drop not flagged or queue changed");
endmodule
